// file: rtl/sysctl_defines.svh
`ifndef SYSCTL_DEFINES_SVH
`define SYSCTL_DEFINES_SVH
// ==========================================
// Register byte addresses
`define ADDR_APP_RESET_CTRL 32'hE000ED0C
`define ADDR_CODE_OPT 32'h1FFF2000
`define ADDR_PRIO_MASK 32'hE000EF00
`define ADDR_CONTROL 32'hE000EF04
`define ADDR_PROC_SP 32'hE000EF08
`define ADDR_MAIN_SP 32'hE000EF0C
`define ADDR_BOOT 32'hE000EF10
// ==========================================
// Field positions and values
`define KEY_HI 31
`define KEY_LO 16
`define KEY_VALUE 16'h05FA
`define BYTE_ORDER_BIT 15
`define RESET_REQ_BIT 2
`define DBG_CLR_BIT 1
`define SEC_HI 31
`define SEC_LO 16
`define SEC_RESET 16'hFFFF
`define SEC_LVL0 16'hFFFF
`define SEC_LVL1 16'h5A5A
`define SEC_LVL2 16'hA5A5
`define OPT_BIT0_RESET 1'h1
`define SPSEL_BIT 1
// ==========================================
// Boot vector locations
`define VEC_SP_ADDR 32'h00000000
`define VEC_PC_ADDR 32'h00000004
`endif

// file: rtl/sysctl_pkg.sv
package sysctl_pkg;
    // ==========================================
    // Bus carriers
    typedef struct packed {
        logic cyc;
        logic stb;
        logic we;
        logic [3:0] sel;
        logic [31:0] adr;
        logic [31:0] dat;
    } wb_req_t;
    typedef struct packed {
        logic ack;
        logic [31:0] dat;
    } wb_rsp_t;
    // ==========================================
    // Boot sequencer states
    typedef enum logic [2:0] {
        ST_FETCH_SP = 3'b001,
        ST_FETCH_PC = 3'b010,
        ST_RUN = 3'b100
    } boot_state_t;
    typedef enum logic [1:0] {
        LVL_ZERO = 2'h0,
        LVL_ONE = 2'h1,
        LVL_TWO = 2'h2
    } sec_level_t;
endpackage : sysctl_pkg

// file: rtl/sysctl_regs.sv
`timescale 1ns/1ps
`include "sysctl_defines.svh"
// Behaviour
// - A control register write counts only if bits 31:16 carry the key, else all is dropped.
// - A keyed write of one to the reset-request bit raises the chip reset request for one cycle.
// - The reset-request bit is write-only, zero does nothing and it always reads zero.
// - Security level field resets to all ones and decodes 0xFFFF, 0x5A5A, 0xA5A5 to levels 0-2.
// - After reset the main stack pointer is loaded from word zero before anything runs.
// - After reset the program counter is loaded from word four and fetching starts there.
// - While the priority mask is set, every configurable-priority exception is blocked.
// - In thread mode the control register picks main or process stack pointer.
module sysctl_regs #(
    parameter int NUM_EXC = 32,
    parameter logic BIG_ENDIAN = 1'b0
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire sysctl_pkg::wb_req_t wb_req_i,
    output sysctl_pkg::wb_rsp_t wb_rsp_o,
    output logic fetch_req_o,
    output logic [31:0] fetch_addr_o,
    input wire logic [31:0] fetch_data_i,
    input wire logic fetch_ack_i,
    output logic core_run_o,
    output logic [31:0] pc_o,
    input wire logic thread_mode_i,
    output logic active_sp_sel_o,
    output logic [31:0] active_sp_o,
    input wire logic [NUM_EXC-1:0] exc_req_i,
    output logic [NUM_EXC-1:0] exc_grant_o,
    output logic chip_reset_request_o,
    output sysctl_pkg::sec_level_t security_level_o
);
    // ==========================================
    // Bus decode
    logic access;
    logic wr;
    logic rd;
    logic key_ok;
    logic ctrl_hit;
    assign access = wb_req_i.cyc && wb_req_i.stb && !wb_rsp_o.ack;
    assign wr = access && wb_req_i.we;
    assign rd = access && !wb_req_i.we;
    assign ctrl_hit = wb_req_i.adr == `ADDR_APP_RESET_CTRL;
    // Key needs both upper lanes, a half-written key is no key
    assign key_ok = (wb_req_i.sel[3:2] == 2'h3)
        && (wb_req_i.dat[`KEY_HI:`KEY_LO] == `KEY_VALUE);

    logic [15:0] sec_q;
    logic opt0_q;
    logic prio_mask_q;
    logic spsel_q;
    logic [31:0] proc_sp_q;
    logic [31:0] main_sp_q;
    sysctl_pkg::boot_state_t state_q;

    // ==========================================
    // Bus answer
    logic [31:0] rdata;
    always_comb begin
        rdata = 32'h00000000;
        // Key, reset-request and debug bits all read zero
        if (ctrl_hit) begin
            rdata[`BYTE_ORDER_BIT] = BIG_ENDIAN;
        end else if (wb_req_i.adr == `ADDR_CODE_OPT) begin
            rdata[`SEC_HI:`SEC_LO] = sec_q;
            rdata[0] = opt0_q;
        end else if (wb_req_i.adr == `ADDR_PRIO_MASK) begin
            rdata[0] = prio_mask_q;
        end else if (wb_req_i.adr == `ADDR_CONTROL) begin
            rdata[`SPSEL_BIT] = spsel_q;
        end else if (wb_req_i.adr == `ADDR_PROC_SP) begin
            rdata = proc_sp_q;
        end else if (wb_req_i.adr == `ADDR_MAIN_SP) begin
            rdata = main_sp_q;
        end else if (wb_req_i.adr == `ADDR_BOOT) begin
            rdata[2:0] = state_q;
        end else begin
            rdata = 32'h00000000;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_rsp_o <= '0;
        end else begin
            wb_rsp_o.ack <= access;
            wb_rsp_o.dat <= rd ? rdata : 32'h00000000;
        end
    end

    // ==========================================
    // Chip reset request
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            chip_reset_request_o <= 1'b0;
        end else begin
            // Whole write dropped without key, lane 0 must carry the bit
            chip_reset_request_o <= wr && ctrl_hit && key_ok && wb_req_i.sel[0]
                && wb_req_i.dat[`RESET_REQ_BIT];
        end
    end

    // ==========================================
    // Code option word
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sec_q <= `SEC_RESET;
            opt0_q <= `OPT_BIT0_RESET;
        end else if (wr && wb_req_i.adr == `ADDR_CODE_OPT) begin
            if (wb_req_i.sel[2]) begin
                sec_q[7:0] <= wb_req_i.dat[23:16];
            end
            if (wb_req_i.sel[3]) begin
                sec_q[15:8] <= wb_req_i.dat[31:24];
            end
            if (wb_req_i.sel[0]) begin
                opt0_q <= wb_req_i.dat[0];
            end
        end
    end

    // Unknown patterns fall back to the open level
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            security_level_o <= sysctl_pkg::LVL_ZERO;
        end else if (sec_q == `SEC_LVL1) begin
            security_level_o <= sysctl_pkg::LVL_ONE;
        end else if (sec_q == `SEC_LVL2) begin
            security_level_o <= sysctl_pkg::LVL_TWO;
        end else begin
            security_level_o <= sysctl_pkg::LVL_ZERO;
        end
    end

    // ==========================================
    // Boot vector fetch
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_q <= sysctl_pkg::ST_FETCH_SP;
            fetch_req_o <= 1'b0;
            fetch_addr_o <= `VEC_SP_ADDR;
            core_run_o <= 1'b0;
            pc_o <= 32'h00000000;
        end else begin
            case (state_q)
                sysctl_pkg::ST_FETCH_SP: begin
                    fetch_req_o <= !fetch_ack_i;
                    if (fetch_req_o && fetch_ack_i) begin
                        state_q <= sysctl_pkg::ST_FETCH_PC;
                        fetch_addr_o <= `VEC_PC_ADDR;
                    end
                end
                sysctl_pkg::ST_FETCH_PC: begin
                    fetch_req_o <= !fetch_ack_i;
                    if (fetch_req_o && fetch_ack_i) begin
                        state_q <= sysctl_pkg::ST_RUN;
                        pc_o <= fetch_data_i;
                        fetch_req_o <= 1'b0;
                        core_run_o <= 1'b1;
                    end
                end
                sysctl_pkg::ST_RUN: begin
                    fetch_req_o <= 1'b0;
                end
                default: begin
                    state_q <= sysctl_pkg::ST_FETCH_SP;
                    fetch_req_o <= 1'b0;
                end
            endcase
        end
    end

    // ==========================================
    // Stack pointers and control
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            main_sp_q <= 32'h00000000;
        end else if (state_q == sysctl_pkg::ST_FETCH_SP && fetch_req_o && fetch_ack_i) begin
            main_sp_q <= fetch_data_i;
        end else if (wr && wb_req_i.adr == `ADDR_MAIN_SP && wb_req_i.sel == 4'hF) begin
            main_sp_q <= wb_req_i.dat;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            proc_sp_q <= 32'h00000000;
        end else if (wr && wb_req_i.adr == `ADDR_PROC_SP && wb_req_i.sel == 4'hF) begin
            proc_sp_q <= wb_req_i.dat;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            spsel_q <= 1'b0;
            prio_mask_q <= 1'b0;
        end else if (wr && wb_req_i.sel[0]) begin
            if (wb_req_i.adr == `ADDR_CONTROL) begin
                spsel_q <= wb_req_i.dat[`SPSEL_BIT];
            end
            if (wb_req_i.adr == `ADDR_PRIO_MASK) begin
                prio_mask_q <= wb_req_i.dat[0];
            end
        end
    end

    // Handler mode always runs on the main stack
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            active_sp_sel_o <= 1'b0;
            active_sp_o <= 32'h00000000;
        end else begin
            active_sp_sel_o <= thread_mode_i && spsel_q;
            active_sp_o <= (thread_mode_i && spsel_q) ? proc_sp_q : main_sp_q;
        end
    end

    // ==========================================
    // Exception gating
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            exc_grant_o <= '0;
        end else begin
            exc_grant_o <= prio_mask_q ? '0 : exc_req_i;
        end
    end

    // ==========================================
    // Checks
    a_key_guard: assert property (@(posedge clk_i) disable iff (rst_i)
        (wr && ctrl_hit && !key_ok) |=> !chip_reset_request_o)
        else $error("reset request taken without key");

    a_reset_taken: assert property (@(posedge clk_i) disable iff (rst_i)
        (wr && ctrl_hit && key_ok && wb_req_i.sel[0] && wb_req_i.dat[2])
        |=> chip_reset_request_o)
        else $error("keyed reset request lost");

    a_pulse_single: assert property (@(posedge clk_i) disable iff (rst_i)
        chip_reset_request_o |=> !chip_reset_request_o)
        else $error("reset request longer than one cycle");

    a_ctrl_read_zero: assert property (@(posedge clk_i) disable iff (rst_i)
        (rd && ctrl_hit) |=> (wb_rsp_o.ack && wb_rsp_o.dat[31:16] == 16'h0000
        && wb_rsp_o.dat[2:0] == 3'h0))
        else $error("write-only bits read non-zero");

    a_sec_reset: assert property (@(posedge clk_i)
        $past(rst_i) |-> (sec_q == 16'hFFFF && opt0_q))
        else $error("code option reset value wrong");

    a_sec_decode: assert property (@(posedge clk_i) disable iff (rst_i)
        (sec_q == 16'hA5A5) |=> (security_level_o == sysctl_pkg::LVL_TWO))
        else $error("security level decode wrong");

    a_sp_load: assert property (@(posedge clk_i) disable iff (rst_i)
        (state_q == sysctl_pkg::ST_FETCH_SP && fetch_req_o && fetch_ack_i)
        |=> (main_sp_q == $past(fetch_data_i) && fetch_addr_o == 32'h00000004 && !core_run_o))
        else $error("stack pointer not loaded from word zero");

    a_pc_load: assert property (@(posedge clk_i) disable iff (rst_i)
        (state_q == sysctl_pkg::ST_FETCH_PC && fetch_req_o && fetch_ack_i)
        |=> (pc_o == $past(fetch_data_i) && core_run_o))
        else $error("program counter not loaded from word four");

    a_mask_block: assert property (@(posedge clk_i) disable iff (rst_i)
        prio_mask_q |=> (exc_grant_o == '0))
        else $error("exception granted while masked");

    a_stack_pick: assert property (@(posedge clk_i) disable iff (rst_i)
        (thread_mode_i && spsel_q) |=> (active_sp_sel_o && active_sp_o == $past(proc_sp_q)))
        else $error("process stack not selected");

    a_bus_answer: assert property (@(posedge clk_i) disable iff (rst_i)
        (access) |=> wb_rsp_o.ack ##1 !wb_rsp_o.ack)
        else $error("bus answer timing wrong");
endmodule : sysctl_regs

// file: verification/sysctl_regs_tb.sv
`timescale 1ns/1ps
`include "sysctl_defines.svh"
module sysctl_regs_tb;
    // ==========================================
    // Signals
    logic clk_i, rst_i, fetch_req, fetch_ack, core_run, thread_mode, sp_sel, rst_req;
    logic [31:0] fetch_addr, fetch_data, pc, sp, exc_req, exc_grant, rdat;
    sysctl_pkg::wb_req_t req;
    sysctl_pkg::wb_rsp_t rsp;
    sysctl_pkg::sec_level_t level;
    int failures, comparisons, pulses;
    logic [15:0] sec_val [3] = '{16'h5A5A, 16'hA5A5, 16'hFFFF};
    logic [1:0] sec_lvl [3] = '{2'h1, 2'h2, 2'h0};
    sysctl_regs sysctl_regs_inst (.clk_i(clk_i), .rst_i(rst_i), .wb_req_i(req), .wb_rsp_o(rsp),
        .fetch_req_o(fetch_req), .fetch_addr_o(fetch_addr), .fetch_data_i(fetch_data),
        .fetch_ack_i(fetch_ack), .core_run_o(core_run), .pc_o(pc), .thread_mode_i(thread_mode),
        .active_sp_sel_o(sp_sel), .active_sp_o(sp), .exc_req_i(exc_req),
        .exc_grant_o(exc_grant), .chip_reset_request_o(rst_req), .security_level_o(level));
    // ==========================================
    // Clock, pulse monitor, watchdog
    initial begin
        clk_i = 1'b0;
        forever #2.5 clk_i = ~clk_i;
    end
    always @(posedge clk_i) begin
        if (rst_i) pulses <= 0;
        else if (rst_req === 1'b1) pulses <= pulses + 1;
    end
    initial begin
        #100000;
        failures++;
        finish_test();
    end
    // ==========================================
    // Tasks
    task automatic finish_test;
        $display("comparisons %0d failures %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : finish_test
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            failures++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    // Holds the request until ack is sampled, then releases for one idle cycle
    task automatic wb(input logic we, input logic [31:0] adr, input logic [31:0] dat,
        input logic [3:0] sel);
        int n;
        n = 0;
        req <= '{cyc: 1'b1, stb: 1'b1, we: we, sel: sel, adr: adr, dat: dat};
        do begin
            @(posedge clk_i);
            n++;
        end while (rsp.ack !== 1'b1 && n < 50);
        if (n >= 50) begin
            failures++;
            finish_test();
        end
        rdat = rsp.dat;
        req <= '0;
        @(posedge clk_i);
    endtask : wb
    task automatic rd(input logic [31:0] adr, input logic [31:0] exp);
        wb(1'b0, adr, 32'h0, 4'hF);
        chk(rdat, exp);
    endtask : rd
    // Memory answers one vector word; data line scrambled once released
    task automatic fetch(input logic [31:0] adr, input logic [31:0] word);
        int n;
        n = 0;
        while (fetch_req !== 1'b1 && n < 20) begin
            @(posedge clk_i);
            n++;
        end
        if (n >= 20) begin
            failures++;
            finish_test();
        end
        chk(fetch_addr, adr);
        fetch_data <= word;
        fetch_ack <= 1'b1;
        @(posedge clk_i);
        fetch_ack <= 1'b0;
        fetch_data <= ~word;
        @(posedge clk_i);
    endtask : fetch
    // ==========================================
    // Main sequence
    initial begin
        rst_i = 1'b1;
        req = '0;
        fetch_data = 32'h0;
        fetch_ack = 1'b0;
        thread_mode = 1'b0;
        exc_req = 32'hA5C3_0F0F;
        repeat (3) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        fetch(`VEC_SP_ADDR, 32'h2000_0FF0);
        fetch(`VEC_PC_ADDR, 32'h0000_01C1);
        chk({31'h0, core_run}, 32'h1);
        chk(pc, 32'h0000_01C1);
        rd(`ADDR_BOOT, 32'h0000_0004);
        rd(`ADDR_MAIN_SP, 32'h2000_0FF0);
        chk(sp, 32'h2000_0FF0);
        rd(`ADDR_APP_RESET_CTRL, 32'h0);
        wb(1'b1, `ADDR_APP_RESET_CTRL, 32'h0000_0004, 4'hF);
        wb(1'b1, `ADDR_APP_RESET_CTRL, {16'h05FB, 16'h0004}, 4'hF);
        wb(1'b1, `ADDR_APP_RESET_CTRL, {16'h05FA, 16'h0000}, 4'hF);
        @(posedge clk_i);
        chk(pulses, 0);
        wb(1'b1, `ADDR_APP_RESET_CTRL, {`KEY_VALUE, 16'h0004}, 4'hF);
        repeat (3) @(posedge clk_i);
        chk(pulses, 1);
        rd(`ADDR_APP_RESET_CTRL, 32'h0);
        rd(`ADDR_CODE_OPT, 32'hFFFF_0001);
        chk({30'h0, level}, 32'h0);
        for (int i = 0; i < 3; i++) begin
            wb(1'b1, `ADDR_CODE_OPT, {sec_val[i], 16'h0001}, 4'hF);
            repeat (2) @(posedge clk_i);
            chk({30'h0, level}, {30'h0, sec_lvl[i]});
            rd(`ADDR_CODE_OPT, {sec_val[i], 16'h0001});
        end
        chk(exc_grant, 32'hA5C3_0F0F);
        wb(1'b1, `ADDR_PRIO_MASK, 32'h1, 4'h1);
        repeat (2) @(posedge clk_i);
        chk(exc_grant, 32'h0);
        wb(1'b1, `ADDR_PRIO_MASK, 32'h0, 4'h1);
        repeat (2) @(posedge clk_i);
        chk(exc_grant, 32'hA5C3_0F0F);
        wb(1'b1, `ADDR_PROC_SP, 32'h2000_0800, 4'hF);
        wb(1'b1, `ADDR_CONTROL, 32'h2, 4'h1);
        repeat (2) @(posedge clk_i);
        chk({sp_sel, sp}, {1'b0, 32'h2000_0FF0});
        thread_mode <= 1'b1;
        repeat (3) @(posedge clk_i);
        chk({sp_sel, sp}, {1'b1, 32'h2000_0800});
        wb(1'b1, 32'hE000_EF40, 32'hFFFF_FFFF, 4'hF);
        rd(32'hE000_EF40, 32'h0);
        finish_test();
    end
endmodule : sysctl_regs_tb
